// *** rtl/rtcisp_slave.sv ***
// two-wire slave port: address match, pointer, write stream, read stream
// assumes open-drain bus resolved outside; memory answers rd_data on the
// clock after rd_addr changes; osc_run comes from logic on this clock
`timescale 1ns/100ps
`default_nettype none
module rtcisp_slave
#(
    parameter int TIMEOUT_CYCLES = rtcisp_pkg::RTCISP_SCL_LOW_LONG_CYC
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // oscillator status
    input wire logic osc_run,
    // write stream to memory
    output var rtcisp_pkg::rtcisp_wr_t wr_item,
    output logic wr_valid,
    input wire logic wr_ready,
    // read port of memory
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data
);
    import rtcisp_pkg::*;

    // ********************
    // pin sampling
    // ********************
    logic scl_s1_reg, scl_s2_reg, scl_s3_reg;
    logic sda_s1_reg, sda_s2_reg, sda_s3_reg;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            scl_s1_reg <= 1'b1;
            scl_s2_reg <= 1'b1;
            scl_s3_reg <= 1'b1;
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
            sda_s3_reg <= 1'b1;
        end
        else
        begin
            scl_s1_reg <= scl_in;
            scl_s2_reg <= scl_s1_reg;
            scl_s3_reg <= scl_s2_reg;
            sda_s1_reg <= sda_in;
            sda_s2_reg <= sda_s1_reg;
            sda_s3_reg <= sda_s2_reg;
        end
    end

    logic scl_rise, scl_fall, start_seen, stop_seen;
    logic [7:0] rx_byte;
    assign scl_rise = scl_s2_reg & ~scl_s3_reg;
    assign scl_fall = ~scl_s2_reg & scl_s3_reg;
    assign start_seen = scl_s2_reg & scl_s3_reg & ~sda_s2_reg & sda_s3_reg;
    assign stop_seen = scl_s2_reg & scl_s3_reg & sda_s2_reg & ~sda_s3_reg;

    // ********************
    // protocol engine
    // ********************
    rtcisp_state_t state_reg, state_next;
    logic [1:0] phase_reg, phase_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] tx_reg, tx_next;
    logic [7:0] ptr_reg, ptr_next;
    logic rw_reg, rw_next;
    logic ack_reg, ack_next;
    logic oe_reg, oe_next;
    logic [RTCISP_TIMER_W-1:0] timer_reg, timer_next;
    logic push;
    logic buf_room;
    rtcisp_wr_t push_item;
    logic timed_out;

    assign rx_byte = {shift_reg[6:0], sda_s2_reg};
    assign timed_out = (int'(timer_reg) >= TIMEOUT_CYCLES - 1) && !scl_s2_reg && osc_run;

    always_comb
    begin
        state_next = state_reg;
        phase_next = phase_reg;
        cnt_next = cnt_reg;
        shift_next = shift_reg;
        tx_next = tx_reg;
        ptr_next = ptr_reg;
        rw_next = rw_reg;
        ack_next = ack_reg;
        oe_next = oe_reg;
        push = 1'b0;
        push_item = '{addr: ptr_reg, data: rx_byte};
        // low-time watchdog runs only with the oscillator
        if (!osc_run || scl_s2_reg)
            timer_next = '0;
        else if (!timed_out)
            timer_next = timer_reg + 1'b1;
        else
            timer_next = timer_reg;
        if (timed_out)
        begin
            state_next = RTCISP_IDLE;
            oe_next = 1'b0;
        end
        else if (start_seen)
        begin
            state_next = RTCISP_RECV;
            phase_next = RTCISP_PH_ADDR;
            cnt_next = 4'h0;
            oe_next = 1'b0;
        end
        else if (stop_seen)
        begin
            state_next = RTCISP_IDLE;
            oe_next = 1'b0;
        end
        else
        begin
            unique case (state_reg)
                RTCISP_IDLE:
                begin
                    oe_next = 1'b0;
                end
                RTCISP_RECV:
                begin
                    if (scl_rise && cnt_reg < RTCISP_BITS_PER_BYTE)
                    begin
                        shift_next = rx_byte;
                        cnt_next = cnt_reg + 1'b1;
                        if (cnt_reg == RTCISP_BITS_PER_BYTE - 4'h1)
                        begin
                            unique case (phase_reg)
                                RTCISP_PH_ADDR:
                                begin
                                    ack_next = (rx_byte[7:1] == RTCISP_SLAVE_ADDR);
                                    rw_next = rx_byte[0];
                                end
                                RTCISP_PH_PTR:
                                begin
                                    ack_next = 1'b1;
                                    ptr_next = rx_byte;
                                end
                                default:
                                begin
                                    ack_next = buf_room; // full buffer answers nack
                                    push = buf_room;
                                    if (buf_room)
                                        ptr_next = ptr_reg + 8'h01;
                                end
                            endcase
                        end
                    end
                    else if (scl_fall && cnt_reg == RTCISP_BITS_PER_BYTE)
                    begin
                        if (ack_reg)
                        begin
                            state_next = RTCISP_RACK;
                            oe_next = 1'b1;
                        end
                        else
                            state_next = RTCISP_IDLE;
                    end
                end
                RTCISP_RACK:
                begin
                    if (scl_fall)
                    begin
                        cnt_next = 4'h0;
                        if (phase_reg == RTCISP_PH_ADDR && rw_reg)
                        begin
                            state_next = RTCISP_SEND;
                            tx_next = rd_data;
                            oe_next = ~rd_data[7];
                        end
                        else
                        begin
                            state_next = RTCISP_RECV;
                            oe_next = 1'b0;
                            if (phase_reg == RTCISP_PH_ADDR)
                                phase_next = RTCISP_PH_PTR;
                            else
                                phase_next = RTCISP_PH_DATA;
                        end
                    end
                end
                RTCISP_SEND:
                begin
                    if (scl_rise)
                        cnt_next = cnt_reg + 1'b1;
                    else if (scl_fall)
                    begin
                        if (cnt_reg == RTCISP_BITS_PER_BYTE)
                        begin
                            state_next = RTCISP_MACK;
                            oe_next = 1'b0;
                            ptr_next = ptr_reg + 8'h01;
                        end
                        else
                        begin
                            tx_next = {tx_reg[6:0], 1'b0};
                            oe_next = ~tx_reg[6];
                        end
                    end
                end
                RTCISP_MACK:
                begin
                    if (scl_rise)
                        ack_next = ~sda_s2_reg;
                    else if (scl_fall)
                    begin
                        cnt_next = 4'h0;
                        if (ack_reg)
                        begin
                            state_next = RTCISP_SEND;
                            tx_next = rd_data;
                            oe_next = ~rd_data[7];
                        end
                        else
                            state_next = RTCISP_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_reg <= RTCISP_IDLE;
            phase_reg <= RTCISP_PH_ADDR;
            cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            ptr_reg <= RTCISP_PTR_RESET;
            rw_reg <= 1'b0;
            ack_reg <= 1'b0;
            oe_reg <= 1'b0;
            timer_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            phase_reg <= phase_next;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            tx_reg <= tx_next;
            ptr_reg <= ptr_next;
            rw_reg <= rw_next;
            ack_reg <= ack_next;
            oe_reg <= oe_next;
            timer_reg <= timer_next;
        end
    end

    // ********************
    // two-entry write buffer
    // ********************
    rtcisp_wr_t head_reg, head_next, tail_reg, tail_next;
    logic head_v_reg, head_v_next, tail_v_reg, tail_v_next;
    logic [7:0] rd_addr_reg;

    assign buf_room = ~tail_v_reg;

    always_comb
    begin
        head_next = head_reg;
        head_v_next = head_v_reg;
        tail_next = tail_reg;
        tail_v_next = tail_v_reg;
        if (head_v_reg && wr_ready)
        begin
            head_next = tail_reg;
            head_v_next = tail_v_reg;
            tail_v_next = 1'b0;
        end
        if (push)
        begin
            if (!head_v_next)
            begin
                head_next = push_item;
                head_v_next = 1'b1;
            end
            else
            begin
                tail_next = push_item;
                tail_v_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            head_reg <= '0;
            tail_reg <= '0;
            head_v_reg <= 1'b0;
            tail_v_reg <= 1'b0;
            rd_addr_reg <= RTCISP_PTR_RESET;
        end
        else
        begin
            head_reg <= head_next;
            tail_reg <= tail_next;
            head_v_reg <= head_v_next;
            tail_v_reg <= tail_v_next;
            rd_addr_reg <= ptr_next;
        end
    end

    // sda only ever pulled low; scl has no driver at all
    assign sda_out = 1'b0;
    assign sda_oe = oe_reg;
    assign wr_item = head_reg;
    assign wr_valid = head_v_reg;
    assign rd_addr = rd_addr_reg;

    // ********************
    // checks
    // ********************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_foreign_nack: assert property (state_reg == RTCISP_RECV && phase_reg == RTCISP_PH_ADDR
        && scl_rise && cnt_reg == 4'h7 && rx_byte[7:1] != RTCISP_SLAVE_ADDR && !start_seen
        && !stop_seen && !timed_out |=> !ack_reg)
        else $error("foreign address acknowledged");
    chk_own_ack: assert property (state_reg == RTCISP_RECV && phase_reg == RTCISP_PH_ADDR
        && scl_rise && cnt_reg == 4'h7 && rx_byte[7:1] == RTCISP_SLAVE_ADDR && !timed_out
        |=> ack_reg && rw_reg == $past(sda_s2_reg))
        else $error("own address not acknowledged");
    chk_ack_drive: assert property (state_reg == RTCISP_RACK |-> oe_reg)
        else $error("ack bit not driven low");
    chk_timeout_reset: assert property (timed_out |=> state_reg == RTCISP_IDLE && !oe_reg)
        else $error("timeout did not release port");
    chk_osc_gate: assert property (!osc_run |=> timer_reg == '0)
        else $error("timer ran without oscillator");
    chk_drive_after_fall: assert property ($rose(oe_reg) |-> $past(scl_fall))
        else $error("sda pulled low outside scl fall");
    chk_pointer_load: assert property (state_reg == RTCISP_RECV && phase_reg == RTCISP_PH_PTR
        && scl_rise && cnt_reg == 4'h7 && !timed_out && !start_seen && !stop_seen
        |=> ##1 rd_addr_reg == $past(rx_byte, 2))
        else $error("pointer not loaded");
    chk_ptr_step: assert property (push |=> ptr_reg == $past(ptr_reg) + 8'h01)
        else $error("address counter did not step");
    chk_msb_order: assert property (state_reg == RTCISP_SEND && scl_fall
        && cnt_reg < 4'h8 && !timed_out && !start_seen && !stop_seen
        |=> oe_reg == ~$past(tx_reg[6]))
        else $error("read bit order wrong");
endmodule
`default_nettype wire

// *** rtl/rtcisp_pkg.sv ***
// constants and types of the two-wire slave port of the clock device
// assumes a 20 MHz system clock; bus pins are sampled, never used as clocks
// Summary of operation
// - first byte after start: address plus direction
// - answer only to fixed address 68 (address byte d0 or d1)
// - direction 0 writes, direction 1 (d1) reads
// - foreign address: no ack, ignore until start
// - second write byte loads the memory pointer
// - multi-byte write accepts each data byte in turn while the write buffer has room; a byte that finds it full gets nack
// - read starts at current address counter value
// - pointer-only write then restart sets read address
// - read continues while master acks each byte
// - scl low past long limit resets port
// - timeout counts only while oscillator runs
// - device never stretches scl
// - sda driven low or released, never high
// - ninth bit is ack low, nack high
// - msb first, device samples on scl rise
// - device changes sda after scl fall
package rtcisp_pkg;

    localparam logic [6:0] RTCISP_SLAVE_ADDR = 7'h68;
    localparam logic [7:0] RTCISP_PTR_RESET = 8'h00;
    localparam int RTCISP_CLK_PERIOD_NS = 50;
    localparam int RTCISP_SCL_LOW_LIMIT_SHORT_US = 25;
    localparam int RTCISP_SCL_LOW_LIMIT_LONG_US = 35;
    localparam int RTCISP_SCL_LOW_LONG_CYC =
        (RTCISP_SCL_LOW_LIMIT_LONG_US * 1000) / RTCISP_CLK_PERIOD_NS;
    localparam int RTCISP_TIMER_W = 20;
    localparam logic [3:0] RTCISP_BITS_PER_BYTE = 4'h8;

    localparam logic [1:0] RTCISP_PH_ADDR = 2'h0;
    localparam logic [1:0] RTCISP_PH_PTR = 2'h1;
    localparam logic [1:0] RTCISP_PH_DATA = 2'h2;

    typedef enum logic [4:0]
    {
        RTCISP_IDLE = 5'h01,
        RTCISP_RECV = 5'h02,
        RTCISP_RACK = 5'h04,
        RTCISP_SEND = 5'h08,
        RTCISP_MACK = 5'h10
    } rtcisp_state_t;

    typedef struct packed
    {
        logic [7:0] addr;
        logic [7:0] data;
    } rtcisp_wr_t;

endpackage

// *** sim/rtcisp_master_model.sv ***
// bus master model: scl push-pull, sda pulled low or released
// assumes sda is resolved outside with a pull-up; steps counted in clk edges
`timescale 1ns/100ps
`default_nettype none
module rtcisp_master_model
(
    // clock
    input wire logic clk,
    // bus pins
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    // ****
    // bus timing
    // ****
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // quarter of a 400 ns bus period; scl never low for long
    task automatic hq();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic start_cond();
        sda_pull = 1'b0;
        hq();
        scl = 1'b1;
        hq();
        sda_pull = 1'b1;
        hq();
        scl = 1'b0;
        hq();
    endtask
    task automatic stop_cond();
        sda_pull = 1'b1;
        hq();
        scl = 1'b1;
        hq();
        sda_pull = 1'b0;
        hq();
        hq();
    endtask
    // data moves only while scl is low, sampled mid high phase
    task automatic xfer_bit(input logic v, output logic r);
        sda_pull = ~v;
        hq();
        scl = 1'b1;
        hq();
        r = sda;
        hq();
        scl = 1'b0;
        hq();
    endtask
    // ****
    // byte transfers
    // ****
    task automatic write_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            xfer_bit(b[i], r);
        xfer_bit(1'b1, r);
        ack = ~r;
    endtask
    task automatic read_byte(input logic more, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            xfer_bit(1'b1, r);
            b[i] = r;
        end
        xfer_bit(~more, r);
    endtask
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// testbench of the two-wire slave port: memory, sink and scenarios
// assumes the package, the slave and the master model are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import rtcisp_pkg::*;
    localparam int TMO = 64;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic osc_run = 1'b1;
    logic wr_ready = 1'b0;
    logic stall = 1'b0;
    logic [7:0] rd_data = 8'h00;
    logic scl;
    logic sda_pull;
    logic sda_out;
    logic sda_oe;
    logic wr_valid;
    logic [7:0] rd_addr;
    rtcisp_wr_t wr_item;
    // open-drain bus: the port's driver value counts only while enabled
    wire logic sda = (sda_oe ? sda_out : 1'b1) & ~sda_pull;
    logic [7:0] mem [256];
    logic [7:0] exp_mem [256];
    logic [7:0] ctr = 8'h00;
    int errors = 0;
    int check_count = 0;
    int cyc = 0;
    always #25 clk = ~clk;
    rtcisp_slave #(.TIMEOUT_CYCLES(TMO)) dut
    (
        .clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .osc_run(osc_run),
        .wr_item(wr_item), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .rd_addr(rd_addr), .rd_data(rd_data)
    );
    rtcisp_master_model m (.clk(clk), .scl(scl), .sda_pull(sda_pull), .sda(sda));
    // ****
    // memory, sink and run limit
    // ****
    always @(posedge clk)
    begin
        rd_data <= mem[rd_addr];
        if (wr_valid && wr_ready)
            mem[wr_item.addr] <= wr_item.data;
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errors++;
            wrap_up();
        end
    end
    always @(posedge clk)
    begin
        #1;
        wr_ready = ~stall & 1'($urandom_range(1));
    end
    // ****
    // checks and sequences
    // ****
    function automatic logic is_ours(input logic [7:0] a);
        return a == 8'hd0;
    endfunction
    task automatic chk_ack(input string what, input logic e, input logic g);
        check_count++;
        if (g !== e)
        begin
            errors++;
            $display("CHECK FAILED %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic addr_ptr(input logic [7:0] a, input logic [7:0] p);
        logic ack;
        m.start_cond();
        m.write_byte(a, ack);
        chk_ack("addr ack", is_ours(a), ack);
        m.write_byte(p, ack);
        chk_ack("pointer ack", is_ours(a), ack);
    endtask
    task automatic write_seq(input logic [7:0] a, input logic [7:0] p, input int n,
        input int n_ok);
        logic ack;
        logic [7:0] b;
        addr_ptr(a, p);
        for (int k = 0; k < n; k++)
        begin
            b = 8'($urandom);
            if (k == 0)
                b[7] = 1'b0;
            m.write_byte(b, ack);
            chk_ack("data ack", k < n_ok, ack);
            if (k < n_ok)
                exp_mem[8'(p + k)] = b;
        end
        m.stop_cond();
        if (is_ours(a))
            ctr = 8'(p + n_ok);
    endtask
    task automatic read_seq(input logic [7:0] p, input int n, input logic dummy);
        logic ack;
        logic [7:0] b;
        if (dummy)
            addr_ptr(8'hd0, p);
        m.start_cond();
        m.write_byte(8'hd1, ack);
        chk_ack("read addr ack", 1'b1, ack);
        for (int k = 0; k < n; k++)
        begin
            m.read_byte(k < n - 1, b);
            chk_byte("read data", exp_mem[8'(p + k)], b);
        end
        m.stop_cond();
        ctr = 8'(p + n);
    endtask
    initial
    begin
        logic [7:0] a;
        logic ack;
        void'($urandom(11));
        for (int i = 0; i < 256; i++)
        begin
            mem[i] = 8'($urandom);
            exp_mem[i] = mem[i];
        end
        repeat (20) @(posedge clk);
        #1;
        reset = 1'b0;
        repeat (5) @(posedge clk);
        write_seq(8'hd0, 8'h10, 4, 4);
        read_seq(8'h10, 4, 1'b1);
        read_seq(ctr, 1, 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            a = 8'($urandom);
            if (a[7:1] == 7'h68)
                a[7:1] = 7'h2a;
            write_seq(a, 8'h40, 2, 0);
        end
        read_seq(ctr, 2, 1'b0);
        write_seq(8'hd0, 8'hfe, 3, 3);
        read_seq(8'hfe, 3, 1'b1);
        // two pending words fill the buffer, the third byte is refused
        stall = 1'b1;
        write_seq(8'hd0, 8'h20, 3, 2);
        stall = 1'b0;
        read_seq(8'h20, 2, 1'b1);
        // hold scl low mid read with the port pulling sda low
        write_seq(8'hd0, 8'h30, 1, 1);
        addr_ptr(8'hd0, 8'h30);
        m.start_cond();
        m.write_byte(8'hd1, ack);
        osc_run = 1'b0;
        repeat (3 * TMO) @(posedge clk);
        #1;
        chk_ack("sda held", 1'b1, sda_oe);
        osc_run = 1'b1;
        repeat (TMO + 6) @(posedge clk);
        #1;
        chk_ack("sda released", 1'b0, sda_oe);
        read_seq(8'h30, 1, 1'b1);
        wrap_up();
    end
endmodule
`default_nettype wire
